// file: ucf_consts.svh
/*
 constants of the serial clock and frame block: register offsets, field positions,
 reset values and sample counts. assumes inclusion by the block and its bench.
*/
// Operation
// - baud down-counter runs on system clock, reloads at zero and on low divisor write
// - one tick each time the counter hits zero, rate clock over divisor plus one
// - transmitter divides ticks by 16 normal, 8 double speed, 2 sync master
// - receiver recovery uses ticks directly with 16, 8 or 2 states by mode
// - divisor is high and low registers together, range 0 to 4095
// - double speed affects async only; software keeps it clear in sync mode
// - double speed receiver uses 8 samples per bit instead of 16
// - slave transfer clock passes a synchroniser then edge detector, two cycles delay
// - in sync mode transfer clock pin is input as slave, output as master
// - polarity zero changes data on rising, samples on falling; one swaps them
// - one start, 5 to 9 data, none even odd parity, one or two stops
// - frame is low start, data lsb first, optional parity, then high stops
// - line idles high; next start bit may follow the last stop at once
// - transmitter and receiver share one format; changing it corrupts received frames in flight
// - receiver checks only the first stop bit; framing error when it is low
// - parity is xor of data bits, inverted for odd parity
// - sync select picks async or sync; clock direction picks master or slave
// - character size value 7 selects nine data bits
// - parity enabled when upper parity mode bit is one
`ifndef UCF_CONSTS_SVH
`define UCF_CONSTS_SVH
`define UCF_CLK_PERIOD_NS 100
`define UCF_OFS_DIVLO 8'h00
`define UCF_OFS_DIVHI 8'h04
`define UCF_OFS_CTLA 8'h08
`define UCF_OFS_CTLB 8'h0c
`define UCF_OFS_CTLC 8'h10
`define UCF_OFS_DATA 8'h14
`define UCF_A_DSPEED 1
`define UCF_A_PERR 2
`define UCF_A_FERR 4
`define UCF_A_TXC 6
`define UCF_A_RXC 7
`define UCF_B_TX8 0
`define UCF_B_RX8 1
`define UCF_B_SIZE2 2
`define UCF_B_TXEN 3
`define UCF_B_RXEN 4
`define UCF_C_POL 0
`define UCF_C_STOP 3
`define UCF_C_SYNC 6
`define UCF_C_DIR 7
`define UCF_RST_DIV 12'h000
`define UCF_RST_SIZE 3'h3
`define UCF_SAMPLES_NORMAL 4'hf
`define UCF_SAMPLES_DOUBLE 4'h7
`define UCF_SAMPLES_SYNC 4'h1
`endif

// file: ucf_pkg.sv
/*
 types of the serial clock and frame block. assumes ucf_consts.svh beside it.
*/
package ucf_pkg;
   typedef enum logic [1:0] {
      UCF_RX_IDLE = 2'b00,
      UCF_RX_START = 2'b01,
      UCF_RX_DATA = 2'b10
   } ucf_rx_state_type;
   typedef struct packed {
      logic [2:0] charSize;
      logic [1:0] parityMode;
      logic stopTwo;
   } ucf_format_type;
   typedef struct packed {
      logic syncSelect;
      logic clockDirection;
      logic clockPolarity;
      logic doubleSpeed;
   } ucf_mode_type;
endpackage : ucf_pkg

// file: ucf_core.sv
/*
 serial clock generator, frame transmitter and receiver behind an apb slave.
 assumes apb inputs and serial pins synchronous to clk_sys except the slave clock.
*/
`timescale 1ns/1ns
`include "ucf_consts.svh"
module ucf_core (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic txd,
   input wire logic rxd,
   input wire logic transferClockIn,
   output logic transferClockOut,
   output logic transferClockOe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   function automatic logic [3:0] dataBits(input logic [2:0] size);
      case (size)
         3'h0: dataBits = 4'h5;
         3'h1: dataBits = 4'h6;
         3'h2: dataBits = 4'h7;
         3'h7: dataBits = 4'h9;
         default: dataBits = 4'h8;
      endcase
   endfunction : dataBits

   function automatic logic [8:0] maskData(input logic [8:0] d, input logic [3:0] n);
      maskData = 9'h000;
      for (int i = 0; i < 9; i++) begin
         if (4'(i) < n) maskData[i] = d[i];
      end
   endfunction : maskData

   function automatic logic parityOf(input logic [8:0] d, input ucf_pkg::ucf_format_type f);
      parityOf = (^maskData(d, dataBits(f.charSize))) ^ f.parityMode[0];
   endfunction : parityOf

   ucf_pkg::ucf_format_type format;
   ucf_pkg::ucf_mode_type mode;
   logic [11:0] baudDivisor;
   logic [11:0] baudCount;
   logic txEnable, rxEnable, txBit8;
   logic [31:0] readValue;
   logic mapped;
   logic xckMeta, xckSync, xckPrev;
   logic [3:0] txDiv, txLeft, rxPhase, rxIdx;
   logic [11:0] txShift;
   logic txFull, txActive, txComplete;
   logic [8:0] txData, rxData;
   logic [10:0] rxBits, next_rxBits;
   logic rxComplete, frameError, parityError, rxBit8;
   ucf_pkg::ucf_rx_state_type rxState;

   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire wrLow = wr && paddr == `UCF_OFS_DIVLO;
   wire wrData = wr && paddr == `UCF_OFS_DATA;
   wire rdData = access && !pwrite && paddr == `UCF_OFS_DATA;
   wire isSync = mode.syncSelect;
   wire master = isSync & mode.clockDirection;
   wire pol = mode.clockPolarity;
   wire baudTick = baudCount == 12'h000;
   wire [3:0] samples = isSync ? `UCF_SAMPLES_SYNC :
      (mode.doubleSpeed ? `UCF_SAMPLES_DOUBLE : `UCF_SAMPLES_NORMAL);
   wire xckRise = xckSync & ~xckPrev;
   wire xckFall = ~xckSync & xckPrev;
   wire changeEdge = master ? baudTick & (transferClockOut == pol)
      : (pol ? xckFall : xckRise);
   wire sampleEdge = master ? baudTick & (transferClockOut != pol)
      : (pol ? xckRise : xckFall);
   wire txBitEn = isSync ? changeEdge : baudTick && txDiv == samples;
   wire [3:0] nBits = dataBits(format.charSize);
   wire parEn = format.parityMode[1];
   wire txLoad = txBitEn && txLeft == 4'h0 && txFull && txEnable;
   wire [3:0] rxLast = nBits + {3'h0, parEn};
   wire bitSample = rxState == ucf_pkg::UCF_RX_DATA &&
      (isSync ? sampleEdge : baudTick && rxPhase == samples);
   wire rxDone = bitSample && rxIdx == rxLast;

   always_comb begin
      mapped = 1'b1;
      readValue = 32'h0000_0000;
      case (paddr)
         `UCF_OFS_DIVLO: readValue[7:0] = baudDivisor[7:0];
         `UCF_OFS_DIVHI: readValue[3:0] = baudDivisor[11:8];
         `UCF_OFS_CTLA: begin
            readValue[`UCF_A_DSPEED] = mode.doubleSpeed;
            readValue[`UCF_A_PERR] = parityError;
            readValue[`UCF_A_FERR] = frameError;
            readValue[`UCF_A_TXC] = txComplete;
            readValue[`UCF_A_RXC] = rxComplete;
         end
         `UCF_OFS_CTLB: begin
            readValue[`UCF_B_TX8] = txBit8;
            readValue[`UCF_B_RX8] = rxBit8;
            readValue[`UCF_B_SIZE2] = format.charSize[2];
            readValue[`UCF_B_TXEN] = txEnable;
            readValue[`UCF_B_RXEN] = rxEnable;
         end
         `UCF_OFS_CTLC: readValue[7:0] = {mode.clockDirection, mode.syncSelect,
            format.parityMode, format.stopTwo, format.charSize[1:0], pol};
         `UCF_OFS_DATA: readValue[7:0] = rxData[7:0];
         default: mapped = 1'b0;
      endcase
   end

   // no wait state: pready rises in the first access cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= (setup & ~pwrite) ? readValue : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         baudDivisor <= `UCF_RST_DIV;
         format <= '{charSize: `UCF_RST_SIZE, parityMode: 2'h0, stopTwo: 1'b0};
         mode <= '0;
         txEnable <= 1'b0;
         rxEnable <= 1'b0;
         txBit8 <= 1'b0;
      end else if (wr) begin
         case (paddr)
            `UCF_OFS_DIVLO: baudDivisor[7:0] <= pwdata[7:0];
            `UCF_OFS_DIVHI: baudDivisor[11:8] <= pwdata[3:0];
            `UCF_OFS_CTLA: mode.doubleSpeed <= pwdata[`UCF_A_DSPEED];
            `UCF_OFS_CTLB: begin
               txBit8 <= pwdata[`UCF_B_TX8];
               format.charSize[2] <= pwdata[`UCF_B_SIZE2];
               txEnable <= pwdata[`UCF_B_TXEN];
               rxEnable <= pwdata[`UCF_B_RXEN];
            end
            `UCF_OFS_CTLC: begin
               mode.clockPolarity <= pwdata[`UCF_C_POL];
               format.charSize[1:0] <= pwdata[2:1];
               format.stopTwo <= pwdata[`UCF_C_STOP];
               format.parityMode <= pwdata[5:4];
               mode.syncSelect <= pwdata[`UCF_C_SYNC];
               mode.clockDirection <= pwdata[`UCF_C_DIR];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         baudCount <= `UCF_RST_DIV;
      end else if (wrLow) begin
         baudCount <= {baudDivisor[11:8], pwdata[7:0]};
      end else if (baudTick) begin
         baudCount <= baudDivisor;
      end else begin
         baudCount <= baudCount - 12'h001;
      end
   end

   // slave clock: first stage read only by the second
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         xckMeta <= 1'b0;
         xckSync <= 1'b0;
         xckPrev <= 1'b0;
      end else begin
         xckMeta <= transferClockIn;
         xckSync <= xckMeta;
         xckPrev <= xckSync;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         transferClockOut <= 1'b0;
         transferClockOe <= 1'b0;
      end else begin
         transferClockOe <= master;
         if (!master) transferClockOut <= pol;
         else if (baudTick) transferClockOut <= ~transferClockOut;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) txDiv <= 4'h0;
      else if (isSync) txDiv <= 4'h0;
      else if (baudTick) txDiv <= (txDiv >= samples) ? 4'h0 : txDiv + 4'h1;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         txd <= 1'b1;
         txShift <= 12'hfff;
         txLeft <= 4'h0;
         txFull <= 1'b0;
         txData <= 9'h000;
         txActive <= 1'b0;
         txComplete <= 1'b0;
      end else begin
         if (txBitEn && txLeft != 4'h0) begin
            txd <= txShift[0];
            txShift <= {1'b1, txShift[11:1]};
            txLeft <= txLeft - 4'h1;
         end else if (txLoad) begin
            txd <= 1'b0;
            txShift <= 12'hfff;
            for (int i = 0; i < 9; i++) begin
               if (4'(i) < nBits) txShift[i] <= txData[i];
            end
            if (parEn) txShift[nBits] <= parityOf(txData, format);
            txLeft <= nBits + {3'h0, parEn} + {3'h0, format.stopTwo} + 4'h1;
         end else if (txBitEn) begin
            txd <= 1'b1;
         end
         if (txLoad) txActive <= 1'b1;
         else if (txBitEn && txLeft == 4'h0) txActive <= 1'b0;
         if (wrData) begin
            txFull <= 1'b1;
            txData <= {txBit8, pwdata[7:0]};
         end else if (txLoad) begin
            txFull <= 1'b0;
         end
         txComplete <= (txBitEn && txLeft == 4'h0 && txActive && !txLoad) |
            (txComplete & ~(wr && paddr == `UCF_OFS_CTLA && pwdata[`UCF_A_TXC]));
      end
   end

   always_comb begin
      next_rxBits = rxBits;
      next_rxBits[rxIdx] = rxd;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rxState <= ucf_pkg::UCF_RX_IDLE;
         rxPhase <= 4'h0;
         rxIdx <= 4'h0;
         rxBits <= 11'h000;
      end else begin
         case (rxState)
            ucf_pkg::UCF_RX_IDLE: begin
               rxIdx <= 4'h0;
               rxPhase <= 4'h0;
               if (rxEnable && !rxd && (isSync ? sampleEdge : baudTick))
                  rxState <= isSync ? ucf_pkg::UCF_RX_DATA : ucf_pkg::UCF_RX_START;
            end
            ucf_pkg::UCF_RX_START: if (baudTick) begin
               rxPhase <= rxPhase + 4'h1;
               if (rxPhase == (samples >> 1)) begin
                  rxPhase <= 4'h0;
                  rxState <= rxd ? ucf_pkg::UCF_RX_IDLE : ucf_pkg::UCF_RX_DATA;
               end
            end
            ucf_pkg::UCF_RX_DATA: begin
               if (baudTick) rxPhase <= (rxPhase == samples) ? 4'h0 : rxPhase + 4'h1;
               if (bitSample) begin
                  rxBits <= next_rxBits;
                  rxIdx <= rxIdx + 4'h1;
                  if (rxDone) rxState <= ucf_pkg::UCF_RX_IDLE;
               end
            end
            default: rxState <= ucf_pkg::UCF_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rxData <= 9'h000;
         rxBit8 <= 1'b0;
         frameError <= 1'b0;
         parityError <= 1'b0;
         rxComplete <= 1'b0;
      end else begin
         if (rxDone) begin
            rxData <= maskData(next_rxBits[8:0], nBits);
            rxBit8 <= next_rxBits[8] & nBits[3] & nBits[0];
            frameError <= !rxd;
            parityError <= parEn &&
               (parityOf(next_rxBits[8:0], format) != next_rxBits[nBits]);
         end
         rxComplete <= rxDone | (rxComplete & ~rdData);
      end
   end

   AST_BAUD_RELOAD: assert property ((baudTick && !wr) |=> baudCount == $past(baudDivisor))
      else $error("counter not reloaded at zero");
   AST_BAUD_PERIOD: assert property ((baudTick && baudDivisor == 12'h001 && !psel)
      |=> !baudTick ##1 baudTick)
      else $error("tick period is not divisor plus one");
   AST_TX_DIVIDE: assert property ((txBitEn && !isSync) |=> (!txBitEn)[*7])
      else $error("async bit clock too fast");
   AST_RX_SAMPLES: assert property ((bitSample && !isSync) |=> (!bitSample)[*7])
      else $error("receiver samples bits too often");
   AST_SYNC_IGNORES_DS: assert property ((master && baudTick)
      |-> txBitEn == (transferClockOut == pol))
      else $error("sync master bit clock wrong");
   AST_SLAVE_DELAY: assert property ((!master && xckRise)
      |-> $past(transferClockIn, 2) && !$past(transferClockIn, 3))
      else $error("slave clock edge delay wrong");
   AST_PIN_DIR: assert property (master |=> transferClockOe)
      else $error("master not driving clock pin");
   AST_START_LOW: assert property (txLoad |=> !txd)
      else $error("frame did not start low");
   AST_IDLE_HIGH: assert property ((txBitEn && txLeft == 4'h0 && !txLoad) |=> txd)
      else $error("idle line not high");
   AST_FRAME_ERR: assert property (rxDone |=> frameError == !$past(rxd))
      else $error("framing error not from first stop");
   // slave clock edges, pin direction and line shape
   AST_SLAVE_FALL_DELAY: assert property ((!master && xckFall)
      |-> !$past(transferClockIn, 2) && $past(transferClockIn, 3))
      else $error("slave clock fall delay wrong");
   AST_SLAVE_PIN_IN: assert property ((isSync && !mode.clockDirection) |=> !transferClockOe)
      else $error("slave drives clock pin");
   AST_CLK_OUT_IDLE: assert property (!master |=> transferClockOut == $past(pol))
      else $error("idle clock output not at polarity level");
   AST_MASTER_HALF_BIT: assert property ((master && txBitEn && !wr)
      |=> !txBitEn)
      else $error("sync master bit clock faster than two ticks");
   AST_TXD_STABLE: assert property (!txBitEn |=> $stable(txd))
      else $error("line changed off a bit boundary");

   COV_BACK_TO_BACK: cover property (txBitEn && txLeft == 4'h0 && txActive && txLoad);
   COV_FRAME_ERR: cover property (rxDone && !rxd);
   COV_SYNC_MASTER_LOAD: cover property (master && txLoad);
   COV_NINE_BITS: cover property (rxDone && nBits == 4'h9);
   COV_SLAVE_LOAD: cover property (isSync && !master && txLoad);
endmodule : ucf_core

// file: ucf_remote.sv
/*
 remote serial peer: drives the receive line with frames and captures frames
 from the transmit line. assumes both lines are timed in clk_sys cycles.
*/
`timescale 1ns/1ns
module ucf_remote (
   input wire logic clk_sys,
   input wire logic txd,
   output logic rxd
);
   // line rests high between frames
   initial rxd = 1'h1;

   // expected frame bits, start first; returns the bit count
   function automatic int build(input logic [8:0] d, input int n, input logic [1:0] par,
         input int stops, output logic [12:0] f);
      f = '1;
      f[0] = 1'h0;
      for (int i = 0; i < n; i++) f[1 + i] = d[i];
      if (par[1]) f[1 + n] = (^(d & ((9'h1 << n) - 9'h1))) ^ par[0];
      return 1 + n + par[1] + stops;
   endfunction : build

   task automatic send(input logic [8:0] d, input int n, input logic [1:0] par,
         input bit badStop, input int bitc);
      logic [12:0] f;
      int len;
      len = build(d, n, par, 1, f);
      f[len - 1] = ~badStop;
      @(posedge clk_sys);
      for (int k = 0; k < len; k++) begin
         rxd <= f[k];
         repeat (bitc) @(posedge clk_sys);
      end
      rxd <= 1'h1;
   endtask : send

   // waits for a start bit, then samples every bit at its middle
   task automatic grab(input int len, input int bitc, output logic [12:0] f,
         output bit ok, output time t0);
      int w;
      f = '1;
      ok = 1'b0;
      w = 0;
      while (txd !== 1'h0 && w < 4000) begin
         @(posedge clk_sys);
         w++;
      end
      if (w < 4000) begin
         t0 = $time;
         repeat (bitc / 2) @(posedge clk_sys);
         for (int k = 0; k < len; k++) begin
            if (k > 0) repeat (bitc) @(posedge clk_sys);
            f[k] = txd;
         end
         ok = 1'b1;
      end
   endtask : grab
endmodule : ucf_remote

// file: ucf_tb.sv
/*
 self-checking bench of the serial clock and frame block over apb.
 assumes ucf_core, ucf_remote and ucf_consts.svh are compiled alongside.
*/
`timescale 1ns/1ns
`include "ucf_consts.svh"
module tb;
   logic clk_sys, reset_n, psel, penable, pwrite, rxd, transferClockIn, perr;
   logic pready, pslverr, txd, transferClockOut, transferClockOe;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int bad_count = 0;
   int total_checks = 0;

   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end

   ucf_core i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txd(txd), .rxd(rxd), .transferClockIn(transferClockIn),
      .transferClockOut(transferClockOut), .transferClockOe(transferClockOe));
   ucf_remote i_peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic alive(input bit ok);
      if (!ok) begin
         bad_count++;
         tally_and_finish();
      end
   endtask : alive

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w;
      w = 0;
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
         w++;
      end while (pready !== 1'h1 && w < 20);
      rd = prdata;
      perr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      alive(w < 20);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input string what);
      apb(1'h0, a, 32'h0);
      chk(what, rd & m, e);
   endtask : rdchk

   // divisor high before low, then format and enables
   task automatic cfg(input int div, input logic dbl, input logic [2:0] sz,
         input logic [1:0] par, input logic two, input logic [1:0] mode, input logic pol,
         input logic tx8);
      wr(`UCF_OFS_DIVHI, 32'(div / 256));
      wr(`UCF_OFS_DIVLO, 32'(div % 256));
      wr(`UCF_OFS_CTLA, {25'h0, 1'h1, 4'h0, dbl, 1'h0});
      wr(`UCF_OFS_CTLC, {24'h0, mode, par, two, sz[1:0], pol});
      wr(`UCF_OFS_CTLB, {27'h0, 1'h1, 1'h1, sz[2], 1'h0, tx8});
   endtask : cfg

   task automatic t_reset();
      rdchk(`UCF_OFS_CTLC, 32'hff, 32'h06, "format reset");
      rdchk(`UCF_OFS_DIVLO, 32'hff, 32'h00, "divisor reset");
      chk("txd idle", txd, 32'h1);
      apb(1'h0, 8'h18, 32'h0);
      chk("unmapped error", perr, 32'h1);
      chk("unmapped data", rd, 32'h0);
      wr(`UCF_OFS_DIVHI, 32'h0f);
      rdchk(`UCF_OFS_DIVHI, 32'h0f, 32'h0f, "divisor high");
   endtask : t_reset

   task automatic tx1(input logic [8:0] d, input logic [2:0] sz, input logic [1:0] par,
         input logic two, input logic dbl, input int div);
      logic [12:0] got, e;
      int n, len, bitc;
      bit ok;
      time t0;
      n = (sz == 3'h7) ? 9 : 5 + int'(sz);
      bitc = (div + 1) * (dbl ? 8 : 16);
      len = i_peer.build(d, n, par, int'(two) + 1, e);
      cfg(div, dbl, sz, par, two, 2'h0, 1'h0, d[8]);
      rdchk(`UCF_OFS_CTLA, 32'h40, 32'h00, "tx complete cleared");
      wr(`UCF_OFS_DATA, {23'h0, d});
      i_peer.grab(len, bitc, got, ok, t0);
      alive(ok);
      chk("tx frame", 32'(got), 32'(e));
      // let the last stop bit finish before touching the format
      repeat (bitc) @(posedge clk_sys);
      rdchk(`UCF_OFS_CTLA, 32'h40, 32'h40, "tx complete set");
   endtask : tx1

   task automatic t_tx_formats();
      tx1(9'h0a5, 3'h3, 2'h0, 1'h0, 1'h0, 0);
      tx1(9'h013, 3'h0, 2'h2, 1'h1, 1'h0, 1);
      tx1(9'h05a, 3'h2, 2'h3, 1'h0, 1'h1, 2);
      tx1(9'h1c6, 3'h7, 2'h2, 1'h0, 1'h0, 0);
      tx1(9'h02d, 3'h1, 2'h3, 1'h1, 1'h0, 0);
   endtask : t_tx_formats

   task automatic t_back_to_back();
      logic [12:0] g0, g1, e0, e1;
      int len;
      bit ok0, ok1;
      time t0, t1;
      len = i_peer.build(9'h0f0, 8, 2'h0, 2, e0);
      len = i_peer.build(9'h00f, 8, 2'h0, 2, e1);
      cfg(0, 1'h0, 3'h3, 2'h0, 1'h1, 2'h0, 1'h0, 1'h0);
      fork
         begin
            i_peer.grab(len, 16, g0, ok0, t0);
            i_peer.grab(len, 16, g1, ok1, t1);
         end
         begin
            wr(`UCF_OFS_DATA, 32'hf0);
            repeat (20) @(posedge clk_sys);
            wr(`UCF_OFS_DATA, 32'h0f);
         end
      join
      alive(ok0 && ok1);
      chk("first frame", 32'(g0), 32'(e0));
      chk("second frame", 32'(g1), 32'(e1));
      chk("start to start", 32'(t1 - t0), 32'(len * 1600));
      repeat (16) @(posedge clk_sys);
   endtask : t_back_to_back

   task automatic t_rx();
      cfg(0, 1'h0, 3'h3, 2'h3, 1'h0, 2'h0, 1'h0, 1'h0);
      i_peer.send(9'h03c, 8, 2'h3, 1'b0, 16);
      rdchk(`UCF_OFS_CTLA, 32'h94, 32'h80, "rx flags clean");
      rdchk(`UCF_OFS_DATA, 32'hff, 32'h3c, "rx data");
      i_peer.send(9'h0c3, 8, 2'h3, 1'b1, 16);
      rdchk(`UCF_OFS_CTLA, 32'h90, 32'h90, "rx framing error");
      rdchk(`UCF_OFS_DATA, 32'hff, 32'hc3, "rx data bad stop");
      cfg(0, 1'h1, 3'h3, 2'h0, 1'h0, 2'h0, 1'h0, 1'h0);
      i_peer.send(9'h05a, 8, 2'h0, 1'b0, 8);
      rdchk(`UCF_OFS_DATA, 32'hff, 32'h5a, "rx double speed");
   endtask : t_rx

   // double speed stays clear in synchronous mode
   task automatic t_sync();
      int toggles;
      logic last;
      cfg(1, 1'h0, 3'h3, 2'h0, 1'h0, 2'h1, 1'h1, 1'h0);
      chk("slave pin enable", transferClockOe, 32'h0);
      chk("slave clock level", transferClockOut, 32'h1);
      cfg(1, 1'h0, 3'h3, 2'h0, 1'h0, 2'h3, 1'h0, 1'h0);
      chk("master pin enable", transferClockOe, 32'h1);
      toggles = 0;
      last = transferClockOut;
      repeat (40) begin
         @(posedge clk_sys);
         if (transferClockOut !== last) toggles++;
         last = transferClockOut;
      end
      chk("master clock toggles", 32'(toggles), 32'h14);
   endtask : t_sync

   // remote clock at an eighth of clk_sys, well under a quarter
   task automatic t_slave();
      logic [12:0] got, e;
      int len;
      len = i_peer.build(9'h0b4, 8, 2'h0, 1, e);
      cfg(1, 1'h0, 3'h3, 2'h0, 1'h0, 2'h1, 1'h0, 1'h0);
      got = '1;
      wr(`UCF_OFS_DATA, 32'hb4);
      for (int k = 0; k < len; k++) begin
         @(posedge clk_sys);
         transferClockIn <= 1'h1;
         repeat (4) @(posedge clk_sys);
         transferClockIn <= 1'h0;
         got[k] = txd;
         repeat (3) @(posedge clk_sys);
      end
      chk("slave tx frame", 32'(got), 32'(e));
   endtask : t_slave

   initial begin
      reset_n = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      transferClockIn = 1'h0;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'h1;
      t_reset();
      t_tx_formats();
      t_back_to_back();
      t_rx();
      t_sync();
      t_slave();
      tally_and_finish();
   end
endmodule : tb
